//--- irc_checker.sv
// Port assertions for the initial reset controller
`timescale 1ns/10ps
`default_nettype none
`include "irc_defs.vh"
module irc_checker #(
  parameter        R_WIDTH  = 12,
  parameter        P_WIDTH  = 16,
  parameter [15:0] P_PULLUP = 16'hFFFF
) (
  input wire logic               i_sys_clk,
  input wire logic               i_rst_b,
  input wire logic               i_reset_pin_b,
  input wire logic               i_wide_stack_pointer_wr,
  input wire logic               i_nibble_stack_pointer_wr,
  input wire logic               i_extension_register_wr,
  input wire logic               o_core_rst,
  input wire logic               o_cpu_run,
  input wire logic [15:0]        o_pc_reset_val,
  input wire logic               o_int_flag_clr,
  input wire logic               o_ext_flag,
  input wire logic               o_int_mask,
  input wire logic               o_key_reset,
  input wire logic               o_tick_2hz,
  input wire logic [R_WIDTH-1:0] o_rport_out,
  input wire logic [P_WIDTH-1:0] o_pport_oe,
  input wire logic [P_WIDTH-1:0] o_pport_pullup
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  pin_sets_rst_a: assert property (!i_reset_pin_b |-> ##2 o_core_rst)
    else $error("pin low without internal reset");
  release_tick_a: assert property ($fell(o_core_rst) |-> $past(o_tick_2hz, 2))
    else $error("reset released outside tick high");
  cpu_run_a: assert property (o_cpu_run == !o_core_rst)
    else $error("run not inverse of reset");
  pc_value_a: assert property (o_core_rst |-> o_pc_reset_val == `IRC_PC_RESET)
    else $error("wrong start address");
  flags_reset_a: assert property (o_core_rst && $past(o_core_rst) |->
    o_int_flag_clr && o_int_mask && !o_ext_flag)
    else $error("flags wrong in reset");
  mask_fall_a: assert property ($fell(o_int_mask) |->
    $past(i_wide_stack_pointer_wr, 2) || $past(i_nibble_stack_pointer_wr, 2))
    else $error("mask dropped without pointer write");
  ext_set_a: assert property (i_extension_register_wr && !o_core_rst |=> o_ext_flag)
    else $error("extension flag not set");
  key_rst_a: assert property (o_key_reset |=> o_core_rst)
    else $error("key request without reset");
  pins_reset_a: assert property (o_core_rst && $past(o_core_rst) && $past(o_core_rst, 2)
    |-> &o_rport_out && o_pport_oe == '0)
    else $error("pins not at defaults");
  pullup_a: assert property (o_pport_pullup == (P_PULLUP[P_WIDTH-1:0] & ~o_pport_oe))
    else $error("pull-up not tied to direction");
endmodule // irc_checker

bind irc_top irc_checker #(.R_WIDTH(R_WIDTH), .P_WIDTH(P_WIDTH), .P_PULLUP(P_PULLUP)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reset_pin_b(i_reset_pin_b),
  .i_wide_stack_pointer_wr(i_wide_stack_pointer_wr),
  .i_nibble_stack_pointer_wr(i_nibble_stack_pointer_wr),
  .i_extension_register_wr(i_extension_register_wr), .o_core_rst(o_core_rst),
  .o_cpu_run(o_cpu_run), .o_pc_reset_val(o_pc_reset_val), .o_int_flag_clr(o_int_flag_clr),
  .o_ext_flag(o_ext_flag), .o_int_mask(o_int_mask), .o_key_reset(o_key_reset),
  .o_tick_2hz(o_tick_2hz), .o_rport_out(o_rport_out), .o_pport_oe(o_pport_oe),
  .o_pport_pullup(o_pport_pullup));
`default_nettype wire

//--- irc_defs.vh
// Constants for the initial reset controller
`ifndef IRC_DEFS_VH
`define IRC_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IRC_SLOW_HZ          32768
`define IRC_TICK_HZ          2
`define IRC_TICK_DIV         16384
`define IRC_KEY_FILT_US      1500
`define IRC_AUTH_MIN_MS      1000

// ----------------------------------------------------------------
// Key combination build options
// ----------------------------------------------------------------
`define IRC_KCOMBO_OFF       2'h0
`define IRC_KCOMBO_ALL4      2'h1
`define IRC_KCOMBO_FIRST3    2'h2
`define IRC_KCOMBO_FIRST2    2'h3

// ----------------------------------------------------------------
// CPU reset values
// ----------------------------------------------------------------
`define IRC_PC_RESET         16'h0110

// ----------------------------------------------------------------
// Port setup write offsets
// ----------------------------------------------------------------
`define IRC_PW_RDATA         3'h0
`define IRC_PW_RSEL          3'h1
`define IRC_PW_PDATA         3'h2
`define IRC_PW_PDIR          3'h3
`define IRC_PW_PSEL          3'h4

// ----------------------------------------------------------------
// Port reset values
// ----------------------------------------------------------------
`define IRC_RDATA_RESET      16'hFFFF
`define IRC_PDIR_RESET       16'h0000
`define IRC_SEL_RESET        16'h0000

`endif

//--- irc_ext_party.sv
// Board reset circuit, keypad and slow crystal model
`timescale 1ns/10ps
`default_nettype none
module irc_ext_party #(
  parameter PIN_MIN  = 40,
  parameter PWR_HOLD = 100
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_pin_req,
  input  wire logic [3:0] i_key_low,
  output var  logic       o_slow_clk,
  output var  logic       o_reset_pin_b,
  output wire logic [3:0] o_keys
);
  int hold_cnt = PWR_HOLD; // Power-on low, scaled down
  initial o_slow_clk = 1'b0;
  initial o_reset_pin_b = 1'b0;
  // Crystal runs from time zero, so filter is live
  always #500 o_slow_clk = ~o_slow_clk;
  always @(posedge i_sys_clk) begin
    if (i_pin_req) begin
      hold_cnt <= PIN_MIN; // Minimum low pulse
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
    o_reset_pin_b <= !(i_pin_req || hold_cnt != 0);
  end
  // Pulled up when released; low only on request
  assign o_keys = ~i_key_low;
endmodule // irc_ext_party
`default_nettype wire

//--- irc_key_filter.v
// Key combination detector with noise filter and time check
`timescale 1ns/10ps
`default_nettype none
`include "irc_defs.vh"

module irc_key_filter #(
  parameter [1:0] COMBO     = `IRC_KCOMBO_ALL4,
  parameter       AUTH_EN   = 0,
  parameter       FILT_CNT  = 50,
  parameter       AUTH_TICK = 3
) (
  input  wire       i_sys_clk,
  input  wire       i_rst_b,
  input  wire       i_slow_en,
  input  wire       i_tick_rise,
  input  wire [3:0] i_keys,
  output reg        o_key_rst
);

  // ----------------------------------------------------------------
  // Combination select
  // ----------------------------------------------------------------
  function combo_low;
    input [1:0] sel;
    input [3:0] k;
    begin
      case (sel)
        `IRC_KCOMBO_ALL4:   combo_low = ~|k;
        `IRC_KCOMBO_FIRST3: combo_low = ~|k[2:0];
        `IRC_KCOMBO_FIRST2: combo_low = ~|k[1:0];
        default:            combo_low = 1'b0;
      endcase
    end
  endfunction

  wire all_low = combo_low(COMBO, i_keys);

  // ----------------------------------------------------------------
  // Noise filter on slow oscillator edges
  // ----------------------------------------------------------------
  // Counts only slow edges, so it stays idle until the oscillator runs
  reg  [7:0] filt_reg;
  reg  [1:0] auth_reg;
  wire       filt_ok = (filt_reg == FILT_CNT[7:0]);

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      filt_reg <= 8'h00;
    end else if (!all_low) begin
      filt_reg <= 8'h00;
    end else if (i_slow_en && !filt_ok) begin
      filt_reg <= filt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Time authorize
  // ----------------------------------------------------------------
  // Third tick edge of a held press lands 1.0 to 1.5 s after it began
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      auth_reg <= 2'h0;
    end else if (!filt_ok) begin
      auth_reg <= 2'h0;
    end else if (i_tick_rise && auth_reg != AUTH_TICK[1:0]) begin
      auth_reg <= auth_reg + 2'h1;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_key_rst <= 1'b0;
    end else if (AUTH_EN != 0) begin
      o_key_rst <= filt_ok && (auth_reg == AUTH_TICK[1:0]);
    end else begin
      o_key_rst <= filt_ok;
    end
  end

endmodule // irc_key_filter

`default_nettype wire

//--- irc_top.v
// Initial reset controller: reset latch, key reset, CPU and pin defaults
// Operation
// - Pin low resets; CPU runs after release.
// - Pin latched; cleared on 2 Hz high.
// - Release may lag up to 250 ms.
// - Pin or keys each reset fully.
// - Key combo option: off, four, three, two.
// - Unselected keys do not matter.
// - Filter idle until oscillator starts.
// - Optional time check, 1 to 1.5 s.
// - PC 0110H, interrupt and extension flags cleared.
// - Interrupts masked until both stack pointers written.
// - Extension write sets flag for next instruction.
// - Outputs high, I/O inputs with pull-up.
// - Special pin functions only after software selects.
`timescale 1ns/10ps
`default_nettype none
`include "irc_defs.vh"

module irc_top #(
  parameter [1:0] KEY_COMBO   = `IRC_KCOMBO_ALL4,
  parameter       TIME_AUTH   = 0,
  parameter       SLOW_HZ     = `IRC_SLOW_HZ,
  parameter       TICK_DIV    = `IRC_TICK_DIV,
  parameter       R_WIDTH     = 12,
  parameter       P_WIDTH     = 16,
  parameter [15:0] P_PULLUP   = 16'hFFFF
) (
  input  wire               i_sys_clk,
  input  wire               i_rst_b,
  input  wire               i_reset_pin_b,
  input  wire               i_slow_oscillator_clock,
  input  wire               i_key_input_0,
  input  wire               i_key_input_1,
  input  wire               i_key_input_2,
  input  wire               i_key_input_3,
  input  wire               i_wide_stack_pointer_wr,
  input  wire               i_nibble_stack_pointer_wr,
  input  wire               i_extension_register_wr,
  input  wire               i_instr_done,
  input  wire               i_port_wr,
  input  wire [2:0]         i_port_addr,
  input  wire [15:0]        i_port_wdata,
  input  wire [R_WIDTH-1:0] i_rport_special,
  input  wire [P_WIDTH-1:0] i_pport_special_out,
  input  wire [P_WIDTH-1:0] i_pport_special_oe,
  output reg                o_core_rst,
  output reg                o_cpu_run,
  output reg  [15:0]        o_pc_reset_val,
  output reg                o_int_flag_clr,
  output reg                o_ext_flag,
  output reg                o_int_mask,
  output reg                o_key_reset,
  output reg                o_tick_2hz,
  output reg  [R_WIDTH-1:0] o_rport_out,
  output reg  [P_WIDTH-1:0] o_pport_out,
  output reg  [P_WIDTH-1:0] o_pport_oe,
  output reg  [P_WIDTH-1:0] o_pport_pullup
);

  // ----------------------------------------------------------------
  // Derived counts
  // ----------------------------------------------------------------
  // Least times round up: filter to whole slow clock periods, time check to whole ticks plus one
  localparam integer FILT_CNT  = (`IRC_KEY_FILT_US * SLOW_HZ + 999999) / 1000000;
  localparam integer AUTH_TICK = (`IRC_AUTH_MIN_MS * `IRC_TICK_HZ + 999) / 1000 + 1;
  localparam integer DIV_HALF  = TICK_DIV / 2;
  // Reset words are 16 bits wide; each register takes its own width
  localparam [15:0]  RDATA_RST = `IRC_RDATA_RESET;
  localparam [15:0]  PDIR_RST  = `IRC_PDIR_RESET;
  localparam [15:0]  SEL_RST   = `IRC_SEL_RESET;

  // ----------------------------------------------------------------
  // Slow oscillator sampling
  // ----------------------------------------------------------------
  reg        osc_s1_reg;
  reg        osc_s2_reg;
  reg        osc_s3_reg;
  wire       slow_en = osc_s2_reg && !osc_s3_reg;

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= i_slow_oscillator_clock;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // 2 Hz divider
  // ----------------------------------------------------------------
  reg  [15:0] div_reg;
  reg  [15:0] div_next;
  reg         tick_prev_reg;
  wire        tick_rise = o_tick_2hz && !tick_prev_reg;

  always @* begin
    div_next = div_reg;
    if (slow_en) begin
      if (div_reg == TICK_DIV[15:0] - 16'h0001) begin
        div_next = 16'h0000;
      end else begin
        div_next = div_reg + 16'h0001;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg       <= 16'h0000;
      o_tick_2hz    <= 1'b0;
      tick_prev_reg <= 1'b0;
    end else begin
      div_reg       <= div_next;
      o_tick_2hz    <= (div_next >= DIV_HALF[15:0]);
      tick_prev_reg <= o_tick_2hz;
    end
  end

  // ----------------------------------------------------------------
  // Key combination reset
  // ----------------------------------------------------------------
  wire key_rst;

  irc_key_filter #(
    .COMBO     (KEY_COMBO),
    .AUTH_EN   (TIME_AUTH),
    .FILT_CNT  (FILT_CNT),
    .AUTH_TICK (AUTH_TICK)
  ) u_key_filter (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_slow_en   (slow_en),
    .i_tick_rise (tick_rise),
    .i_keys      ({i_key_input_3, i_key_input_2, i_key_input_1, i_key_input_0}),
    .o_key_rst   (key_rst)
  );

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_key_reset <= 1'b0;
    end else begin
      o_key_reset <= key_rst;
    end
  end

  // ----------------------------------------------------------------
  // Reset latch
  // ----------------------------------------------------------------
  // Set wins over release, so a request during the tick is never lost
  wire rst_set = !i_reset_pin_b || key_rst;
  reg  rst_latch_reg;

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_latch_reg <= 1'b1;
    end else if (rst_set) begin
      rst_latch_reg <= 1'b1;
    end else if (o_tick_2hz) begin
      rst_latch_reg <= 1'b0;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_core_rst     <= 1'b1;
      o_cpu_run      <= 1'b0;
      o_int_flag_clr <= 1'b1;
      o_pc_reset_val <= `IRC_PC_RESET;
    end else begin
      o_core_rst     <= rst_latch_reg;
      o_cpu_run      <= !rst_latch_reg;
      o_int_flag_clr <= rst_latch_reg;
      o_pc_reset_val <= `IRC_PC_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer interrupt mask
  // ----------------------------------------------------------------
  reg sp_wide_reg;
  reg sp_nib_reg;
  reg both_set;

  always @* begin
    both_set = sp_wide_reg && sp_nib_reg;
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sp_wide_reg <= 1'b0;
      sp_nib_reg  <= 1'b0;
    end else if (o_core_rst) begin
      sp_wide_reg <= 1'b0;
      sp_nib_reg  <= 1'b0;
    end else if (i_wide_stack_pointer_wr && i_nibble_stack_pointer_wr) begin
      sp_wide_reg <= 1'b1;
      sp_nib_reg  <= 1'b1;
    end else if (i_wide_stack_pointer_wr) begin
      // Rewriting one pointer re-masks until its partner follows
      sp_wide_reg <= 1'b1;
      sp_nib_reg  <= both_set ? 1'b0 : sp_nib_reg;
    end else if (i_nibble_stack_pointer_wr) begin
      sp_nib_reg  <= 1'b1;
      sp_wide_reg <= both_set ? 1'b0 : sp_wide_reg;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_int_mask <= 1'b1;
    end else begin
      o_int_mask <= o_core_rst || !both_set;
    end
  end

  // ----------------------------------------------------------------
  // Extension flag
  // ----------------------------------------------------------------
  // Write sets it; the end of the following instruction clears it
  reg ext_armed_reg;

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ext_flag    <= 1'b0;
      ext_armed_reg <= 1'b0;
    end else if (o_core_rst) begin
      o_ext_flag    <= 1'b0;
      ext_armed_reg <= 1'b0;
    end else if (i_extension_register_wr) begin
      o_ext_flag    <= 1'b1;
      ext_armed_reg <= i_instr_done;
    end else if (i_instr_done) begin
      if (ext_armed_reg) begin
        o_ext_flag    <= 1'b0;
        ext_armed_reg <= 1'b0;
      end else begin
        ext_armed_reg <= o_ext_flag;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared pin setup registers
  // ----------------------------------------------------------------
  reg [R_WIDTH-1:0] rdata_reg;
  reg [R_WIDTH-1:0] rsel_reg;
  reg [P_WIDTH-1:0] pdata_reg;
  reg [P_WIDTH-1:0] pdir_reg;
  reg [P_WIDTH-1:0] psel_reg;
  wire              pw = i_port_wr && !o_core_rst;

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= RDATA_RST[R_WIDTH-1:0];
      rsel_reg  <= SEL_RST[R_WIDTH-1:0];
      pdata_reg <= RDATA_RST[P_WIDTH-1:0];
      pdir_reg  <= PDIR_RST[P_WIDTH-1:0];
      psel_reg  <= SEL_RST[P_WIDTH-1:0];
    end else if (o_core_rst) begin
      rdata_reg <= RDATA_RST[R_WIDTH-1:0];
      rsel_reg  <= SEL_RST[R_WIDTH-1:0];
      pdata_reg <= RDATA_RST[P_WIDTH-1:0];
      pdir_reg  <= PDIR_RST[P_WIDTH-1:0];
      psel_reg  <= SEL_RST[P_WIDTH-1:0];
    end else if (pw) begin
      case (i_port_addr)
        `IRC_PW_RDATA: rdata_reg <= i_port_wdata[R_WIDTH-1:0];
        `IRC_PW_RSEL:  rsel_reg  <= i_port_wdata[R_WIDTH-1:0];
        `IRC_PW_PDATA: pdata_reg <= i_port_wdata[P_WIDTH-1:0];
        `IRC_PW_PDIR:  pdir_reg  <= i_port_wdata[P_WIDTH-1:0];
        `IRC_PW_PSEL:  psel_reg  <= i_port_wdata[P_WIDTH-1:0];
        default:       rdata_reg <= rdata_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Registered so pins never glitch while functions switch over
  reg [P_WIDTH-1:0] oe_next;

  always @* begin
    oe_next = (psel_reg & i_pport_special_oe) | (~psel_reg & pdir_reg);
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rport_out    <= {R_WIDTH{1'b1}};
      o_pport_out    <= {P_WIDTH{1'b1}};
      o_pport_oe     <= {P_WIDTH{1'b0}};
      o_pport_pullup <= P_PULLUP[P_WIDTH-1:0];
    end else begin
      o_rport_out    <= (rsel_reg & i_rport_special) | (~rsel_reg & rdata_reg);
      o_pport_out    <= (psel_reg & i_pport_special_out) | (~psel_reg & pdata_reg);
      o_pport_oe     <= oe_next;
      o_pport_pullup <= P_PULLUP[P_WIDTH-1:0] & ~oe_next;
    end
  end

endmodule // irc_top

`default_nettype wire

//--- irc_top_bench.sv
// Testbench for the initial reset controller
`timescale 1ns/10ps
`default_nettype none
`include "irc_defs.vh"
module irc_top_bench;
  // Pin hold, half tick period and margin, in sys cycles
  localparam int REL_MAX = 40 + 8 * 20 + 20;
  logic clk = 1'b0, rst_b = 1'b0, pin_req = 1'b0, sp_w = 1'b0, sp_n = 1'b0;
  logic ext_wr = 1'b0, done = 1'b0, port_wr = 1'b0;
  logic [2:0] port_addr = 3'h0;
  logic [15:0] port_wdata = 16'h0000;
  logic [3:0] key_low = 4'h0, keys;
  logic pin_b, slow;
  wire logic [3:0] core_rst, cpu_run, int_clr, ext_flag, int_mask, key_rst, tick;
  wire logic auth_key;
  wire logic [11:0] rport [4];
  wire logic [15:0] pc [4], pout [4], poe [4], ppu [4];
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #25 clk = ~clk;
  irc_ext_party part_u (.i_sys_clk(clk), .i_pin_req(pin_req), .i_key_low(key_low),
    .o_slow_clk(slow), .o_reset_pin_b(pin_b), .o_keys(keys));
  // One instance per key option; index 1 carries the other tests
  for (genvar g = 0; g < 4; g++) begin : gen_c
    irc_top #(.KEY_COMBO(2'(g)), .SLOW_HZ(4000), .TICK_DIV(16)) dut_u (
      .i_sys_clk(clk), .i_rst_b(rst_b), .i_reset_pin_b(pin_b),
      .i_slow_oscillator_clock(slow), .i_key_input_0(keys[0]), .i_key_input_1(keys[1]),
      .i_key_input_2(keys[2]), .i_key_input_3(keys[3]),
      .i_wide_stack_pointer_wr(sp_w), .i_nibble_stack_pointer_wr(sp_n),
      .i_extension_register_wr(ext_wr), .i_instr_done(done), .i_port_wr(port_wr),
      .i_port_addr(port_addr), .i_port_wdata(port_wdata), .i_rport_special(12'h5A3),
      .i_pport_special_out(16'h0000), .i_pport_special_oe(16'hFFFF),
      .o_core_rst(core_rst[g]), .o_cpu_run(cpu_run[g]), .o_pc_reset_val(pc[g]),
      .o_int_flag_clr(int_clr[g]), .o_ext_flag(ext_flag[g]), .o_int_mask(int_mask[g]),
      .o_key_reset(key_rst[g]), .o_tick_2hz(tick[g]), .o_rport_out(rport[g]),
      .o_pport_out(pout[g]), .o_pport_oe(poe[g]), .o_pport_pullup(ppu[g]));
  end
  // Time check build with the four-key combination
  if (1) begin : gen_a
    irc_top #(.TIME_AUTH(1), .SLOW_HZ(4000), .TICK_DIV(16)) dut_u (
      .i_sys_clk(clk), .i_rst_b(rst_b), .i_reset_pin_b(pin_b),
      .i_slow_oscillator_clock(slow), .i_key_input_0(keys[0]), .i_key_input_1(keys[1]),
      .i_key_input_2(keys[2]), .i_key_input_3(keys[3]),
      .i_wide_stack_pointer_wr(sp_w), .i_nibble_stack_pointer_wr(sp_n),
      .i_extension_register_wr(ext_wr), .i_instr_done(done), .i_port_wr(port_wr),
      .i_port_addr(port_addr), .i_port_wdata(port_wdata), .i_rport_special(12'h5A3),
      .i_pport_special_out(16'h0000), .i_pport_special_oe(16'hFFFF),
      .o_core_rst(), .o_cpu_run(), .o_pc_reset_val(), .o_int_flag_clr(), .o_ext_flag(),
      .o_int_mask(), .o_key_reset(auth_key), .o_tick_2hz(), .o_rport_out(),
      .o_pport_out(), .o_pport_oe(), .o_pport_pullup());
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    check_vec(name, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic wait_free(input int lim);
    int n = 0;
    while (core_rst !== 4'h0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    #1;
    check_bit("release in time", 1'b1, n < lim);
  endtask
  task automatic port_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk); port_wr <= 1'b1; port_addr <= a; port_wdata <= d;
    @(posedge clk); port_wr <= 1'b0;
    @(posedge clk); #1;
  endtask
  task automatic pin_reset;
    @(posedge clk); pin_req <= 1'b1;
    @(posedge clk); pin_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check_vec("core_rst", 16'h000F, {12'h000, core_rst});
    wait_free(REL_MAX);
  endtask
  task automatic sp_write(input logic w, input logic n, input logic m);
    @(posedge clk); sp_w <= w; sp_n <= n;
    @(posedge clk); sp_w <= 1'b0; sp_n <= 1'b0;
    @(posedge clk); #1;
    check_bit("int_mask", m, int_mask[1]);
  endtask
  task automatic pins_default;
    check_vec("rport", 16'h0FFF, {4'h0, rport[1]});
    check_vec("pport_out", 16'hFFFF, pout[1]);
    check_vec("pport_oe", 16'h0000, poe[1]);
    check_vec("pullup", 16'hFFFF, ppu[1]);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_boot;
    repeat (16) @(posedge clk);
    #1;
    check_bit("core_rst", 1'b1, core_rst[1]);
    check_vec("pc_reset", `IRC_PC_RESET, pc[1]);
    check_bit("ext_flag", 1'b0, ext_flag[1]);
    check_bit("int_clr", 1'b1, int_clr[1]);
    pins_default();
    @(posedge clk); rst_b <= 1'b1;
    port_write(`IRC_PW_RDATA, 16'h0000); // Lands while still in reset
    wait_free(400);
    pins_default();
    check_bit("cpu_run", 1'b1, cpu_run[1]);
    check_bit("int_mask", 1'b1, int_mask[1]);
    check_bit("int_clr", 1'b0, int_clr[1]);
  endtask
  // High half of the tick is half the divider, 8 slow edges of 20 cycles
  task automatic t_tick;
    int n = 0;
    @(posedge tick[1]);
    #1;
    while (tick[1] === 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check_vec("tick high", 16'h00A0, n[15:0]);
  endtask
  task automatic t_ext;
    @(posedge clk); ext_wr <= 1'b1; done <= 1'b1;
    @(posedge clk); ext_wr <= 1'b0; done <= 1'b0;
    #1;
    check_bit("ext_flag", 1'b1, ext_flag[1]);
    @(posedge clk); done <= 1'b1;
    @(posedge clk); done <= 1'b0;
    #1;
    check_bit("ext_flag", 1'b0, ext_flag[1]);
  endtask
  task automatic t_ports;
    port_write(`IRC_PW_RDATA, 16'h0F0F);
    check_vec("rport", 16'h0F0F, {4'h0, rport[1]});
    port_write(`IRC_PW_RSEL, 16'h00FF);
    check_vec("rport", 16'h0FA3, {4'h0, rport[1]});
    port_write(`IRC_PW_PDIR, 16'h00F0);
    port_write(`IRC_PW_PDATA, 16'h1234);
    check_vec("pport_oe", 16'h00F0, poe[1]);
    check_vec("pport_out", 16'h1234, pout[1]);
    check_vec("pullup", 16'hFF0F, ppu[1]);
    port_write(`IRC_PW_PSEL, 16'h000F);
    check_vec("pport_oe", 16'h00FF, poe[1]);
    check_vec("pport_out", 16'h1230, pout[1]);
    check_vec("pullup", 16'hFF00, ppu[1]);
    port_write(3'h7, 16'h0000);
    check_vec("rport", 16'h0FA3, {4'h0, rport[1]});
    pin_reset();
    pins_default();
    check_bit("int_mask", 1'b1, int_mask[1]);
  endtask
  task automatic t_keys;
    logic [3:0] pat [4] = '{4'h3, 4'h7, 4'hF, 4'h1};
    logic [3:0] sel [4] = '{4'h0, 4'hF, 4'h7, 4'h3};
    @(posedge clk); key_low <= 4'hF;
    repeat (40) @(posedge clk); // Two slow cycles, below the filter
    key_low <= 4'h0;
    #1;
    check_vec("key_reset", 16'h0000, {12'h000, key_rst});
    for (int p = 0; p < 4; p++) begin
      @(posedge clk); key_low <= pat[p];
      repeat (200) @(posedge clk);
      #1;
      for (int c = 0; c < 4; c++)
        check_bit("key_reset", c != 0 && (sel[c] & ~pat[p]) == 4'h0, key_rst[c]);
      @(posedge clk); key_low <= 4'h0;
      wait_free(400);
    end
  endtask
  // Three tick rises of a held press: 640 to 960 cycles after the filter
  task automatic t_auth;
    @(posedge clk); key_low <= 4'hF;
    repeat (600) @(posedge clk);
    #1;
    check_bit("auth key_reset", 1'b0, auth_key);
    repeat (600) @(posedge clk);
    #1;
    check_bit("auth key_reset", 1'b1, auth_key);
    @(posedge clk); key_low <= 4'h0;
    wait_free(400);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    t_boot();
    t_tick();
    sp_write(1'b1, 1'b0, 1'b1);
    sp_write(1'b0, 1'b1, 1'b0);
    sp_write(1'b0, 1'b1, 1'b1);
    sp_write(1'b1, 1'b0, 1'b0);
    sp_write(1'b1, 1'b1, 1'b0);
    t_ext();
    t_ports();
    t_keys();
    t_auth();
    summarize();
  end
endmodule // irc_top_bench
`default_nettype wire
